// [lpm_pkg.sv]
/*
 * package for the low power mode manager: power modes, the grouped
 * link status and wake source carriers, and the cycle counts.
 * assumes one 100 MHz core clock and no register bus.
 */
package lpm_pkg;

    // power mode held by the controller
    typedef enum logic [1:0] {
        LPM_ACTIVE,
        LPM_SLEEP,
        LPM_DEEP
    } lpm_mode_t;

    // radio link activity reported by the baseband scheduler
    typedef struct packed {
        logic acl_active;     // asynchronous link in active state
        logic sco_active;     // synchronous link in active state
        logic sniff_park;     // a link sits in sniff, hold or park
        logic scan_enabled;   // page or inquiry scan enabled
        logic radio_busy;     // scheduled slot activity right now
        logic event_due;      // sniff instant, beacon or scan window due
    } lpm_link_t;

    // wake sources
    typedef struct packed {
        logic [15:0] gpio;            // general purpose pins
        logic usb;                    // usb bus activity
        logic debug_serial_receive;   // debug serial receive line
        logic host_serial_receive;    // host serial receive line
        logic external_irq_a;         // external interrupt a
        logic external_irq_b;         // external interrupt b
    } lpm_wake_t;

    // number of wake sources, for the reduction width
    localparam int LPM_WAKE_W = 21;

    // idle time before dropping to a low power mode
    localparam int LPM_IDLE_NS = 100;
    localparam int LPM_CLK_NS = 10;
    localparam int LPM_IDLE_CYC = (LPM_IDLE_NS + LPM_CLK_NS - 1) / LPM_CLK_NS;
    localparam int LPM_IDLE_W = 4;

    // reset value of the idle counter
    localparam logic [3:0] LPM_IDLE_RST = 4'h0;

endpackage : lpm_pkg

// [lpm_sync_edge.sv]
/*
 * registered activity detector: flags any change or high level on a
 * group of wake inputs.
 * assumes inputs synchronous to core_clk.
 */
`timescale 1ns/1ps
module lpm_sync_edge #(
    parameter int W = 21
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [W-1:0] din,
    output logic active
);
    logic [W-1:0] prev;  // last sample of the inputs
    wire any_high = |din;
    wire any_edge = |(din ^ prev);

    // sample and flag level or edge activity
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            prev <= '0;
            active <= 1'b0;
        end else begin
            prev <= din;
            active <= any_high | any_edge;
        end
    end
endmodule : lpm_sync_edge

// [lpm_idle_timer.sv]
/*
 * idle timer: counts quiet cycles and reports when the idle span is met.
 * assumes clear is a level from the caller.
 */
`timescale 1ns/1ps
module lpm_idle_timer (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic clear,
    output logic idle
);
    logic [lpm_pkg::LPM_IDLE_W-1:0] count;  // quiet cycles seen
    localparam logic [lpm_pkg::LPM_IDLE_W-1:0] LIMIT =
        lpm_pkg::LPM_IDLE_W'(lpm_pkg::LPM_IDLE_CYC);
    wire at_limit = (count == LIMIT);

    // count up while quiet, saturate at the limit
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            count <= lpm_pkg::LPM_IDLE_RST;
            idle <= 1'b0;
        end else if (clear) begin
            count <= lpm_pkg::LPM_IDLE_RST;
            idle <= 1'b0;
        end else begin
            count <= at_limit ? count : count + 1'b1;
            idle <= at_limit;
        end
    end
endmodule : lpm_idle_timer

// [lpm_manager.sv]
/*
 * low power mode manager: picks active, sleep or deep sleep from link
 * and host transport activity and drives the clock gates.
 * assumes all inputs synchronous to core_clk; core_clk itself is the
 * always-on domain, the gated clocks are enables for clock cells.
 */
// Overview of operation
// - mode chosen autonomously from link and host
// - sleep keeps commands, scans, links, data
// - sleep gates clock only in part
// - deep sleep refuses commands and payload data
// - deep sleep stops clock everywhere
// - deep sleep wakes active for scan windows
// - no deep sleep on usb transport
// - idle span moves active into sleep, or deep if deep_ok; sniff_park not read
// - deep sleep goes active for sniff/beacon exchange
// - uart reactivation moves deep to sleep
// - scan only: sleep or deep between windows
// - no connection, uart low: deep sleep
// - active sco or acl forbids deep sleep
// - active links sleep when idle time
// - wake on gpio, usb, uarts, irqs
// - slow clock is reference in low power
`timescale 1ns/1ps
module lpm_manager (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire lpm_pkg::lpm_link_t link,
    input wire lpm_pkg::lpm_wake_t wake,
    input wire logic uart_low_power,
    input wire logic usb_transport,
    input wire logic host_cmd_pending,
    output lpm_pkg::lpm_mode_t mode,
    output logic part_clk_en,
    output logic main_clk_en,
    output logic sys_clk_req,
    output logic host_cmd_accept,
    output logic payload_en,
    output logic slow_clk_ref
);
    lpm_pkg::lpm_mode_t next_mode;  // mode for the next cycle
    logic wake_act;                 // registered wake activity
    logic idle;                     // idle span reached
    logic returned;                 // active visit started from deep

    // pack the wake sources for the detector
    wire [lpm_pkg::LPM_WAKE_W-1:0] wake_vec = wake;

    // any wake source counts as activity
    lpm_sync_edge #(.W(lpm_pkg::LPM_WAKE_W)) u_wake (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .din(wake_vec),
        .active(wake_act)
    );

    // activity that holds the core awake
    wire busy = link.radio_busy | host_cmd_pending | link.event_due;
    // connected links that are not parked or sniffing
    wire live_link = link.acl_active | link.sco_active;
    // deep sleep permitted only with uart idle and no usb
    wire deep_ok = uart_low_power & ~usb_transport & ~live_link;
    // host reopened the uart or woke the part
    wire host_wake = ~uart_low_power | wake_act;

    // quiet span before dropping from active
    lpm_idle_timer u_idle (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .clear(busy | wake_act),
        .idle(idle)
    );

    // low power target once idle: deep if allowed, else sleep
    wire lp_target_deep = deep_ok;

    // mode decision, no command involved
    always_comb begin
        next_mode = mode;
        case (mode)
            lpm_pkg::LPM_ACTIVE: begin
                // sniff/park, scans or quiet links drop out
                if (returned && !busy && deep_ok) begin
                    next_mode = lpm_pkg::LPM_DEEP;
                end else if (idle && lp_target_deep) begin
                    next_mode = lpm_pkg::LPM_DEEP;
                end else if (idle) begin
                    next_mode = lpm_pkg::LPM_SLEEP;
                end
            end
            lpm_pkg::LPM_SLEEP: begin
                // slot work or a command brings full clock back
                if (busy) begin
                    next_mode = lpm_pkg::LPM_ACTIVE;
                end else if (deep_ok && !wake_act) begin
                    next_mode = lpm_pkg::LPM_DEEP;
                end
            end
            lpm_pkg::LPM_DEEP: begin
                // scheduled radio event wins over host wake
                if (link.event_due) begin
                    next_mode = lpm_pkg::LPM_ACTIVE;
                end else if (host_wake || !deep_ok) begin
                    next_mode = lpm_pkg::LPM_SLEEP;
                end
            end
            default: next_mode = lpm_pkg::LPM_ACTIVE;
        endcase
    end

    // mode register, active after reset
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            mode <= lpm_pkg::LPM_ACTIVE;
        end else begin
            mode <= next_mode;
        end
    end

    // remember a visit to active that began in deep sleep
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            returned <= 1'b0;
        end else if (mode == lpm_pkg::LPM_DEEP) begin
            returned <= (next_mode == lpm_pkg::LPM_ACTIVE);
        end else if (mode == lpm_pkg::LPM_SLEEP) begin
            returned <= 1'b0;
        end
    end

    // output decode from the next mode so outputs align with mode
    wire n_active = (next_mode == lpm_pkg::LPM_ACTIVE);
    wire n_deep = (next_mode == lpm_pkg::LPM_DEEP);
    wire n_sleep = (next_mode == lpm_pkg::LPM_SLEEP);

    // clock gates and service enables, all registered
    // trade-off: part clock stays on in sleep so links keep time
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            part_clk_en <= 1'b1;
            main_clk_en <= 1'b1;
            sys_clk_req <= 1'b1;
            host_cmd_accept <= 1'b1;
            payload_en <= 1'b1;
            slow_clk_ref <= 1'b0;
        end else begin
            part_clk_en <= ~n_deep;
            main_clk_en <= n_active;
            sys_clk_req <= ~n_deep;
            host_cmd_accept <= ~n_deep;
            payload_en <= ~n_deep;
            slow_clk_ref <= n_sleep | n_deep;
        end
    end

    // no deep sleep with a live link or on usb
    property p_no_deep_live;
        @(posedge core_clk) disable iff (!arst_n)
        (live_link | usb_transport) |=> (mode != lpm_pkg::LPM_DEEP);
    endproperty
    a_no_deep_live: assert property (p_no_deep_live)
        else $error("deep sleep with live link or usb");

    // deep sleep stops the part and main clocks
    property p_deep_clk;
        @(posedge core_clk) disable iff (!arst_n)
        (mode == lpm_pkg::LPM_DEEP) |-> (!part_clk_en && !main_clk_en);
    endproperty
    a_deep_clk: assert property (p_deep_clk)
        else $error("clock running in deep sleep");

    // sleep keeps part clock only
    property p_sleep_clk;
        @(posedge core_clk) disable iff (!arst_n)
        (mode == lpm_pkg::LPM_SLEEP) |-> (part_clk_en && !main_clk_en);
    endproperty
    a_sleep_clk: assert property (p_sleep_clk)
        else $error("sleep clock gating wrong");

    // deep sleep refuses commands and payload
    property p_deep_refuse;
        @(posedge core_clk) disable iff (!arst_n)
        (mode == lpm_pkg::LPM_DEEP) |-> (!host_cmd_accept && !payload_en);
    endproperty
    a_deep_refuse: assert property (p_deep_refuse)
        else $error("deep sleep accepts traffic");

    // sleep keeps serving commands and data
    property p_sleep_serve;
        @(posedge core_clk) disable iff (!arst_n)
        (mode == lpm_pkg::LPM_SLEEP) |-> (host_cmd_accept && payload_en);
    endproperty
    a_sleep_serve: assert property (p_sleep_serve)
        else $error("sleep refuses traffic");

    // a due event in deep sleep makes the core active next cycle
    property p_event_wake;
        @(posedge core_clk) disable iff (!arst_n)
        (mode == lpm_pkg::LPM_DEEP && link.event_due)
            |=> (mode == lpm_pkg::LPM_ACTIVE && sys_clk_req);
    endproperty
    a_event_wake: assert property (p_event_wake)
        else $error("no wake for due event");

    // uart reopened in deep sleep moves to sleep
    property p_uart_wake;
        @(posedge core_clk) disable iff (!arst_n)
        (mode == lpm_pkg::LPM_DEEP && !uart_low_power && !link.event_due)
            |=> (mode == lpm_pkg::LPM_SLEEP);
    endproperty
    a_uart_wake: assert property (p_uart_wake)
        else $error("uart reopen did not leave deep sleep");

    // slow clock reference follows low power modes
    property p_slow_ref;
        @(posedge core_clk) disable iff (!arst_n)
        slow_clk_ref == (mode != lpm_pkg::LPM_ACTIVE);
    endproperty
    a_slow_ref: assert property (p_slow_ref)
        else $error("slow clock reference mismatch");

    // long quiet span in active leaves active
    sequence s_quiet;
        (mode == lpm_pkg::LPM_ACTIVE && !busy && !wake_act
         && !link.event_due) [*8];
    endsequence
    property p_idle_leave;
        @(posedge core_clk) disable iff (!arst_n)
        s_quiet |-> ##[1:8] (mode != lpm_pkg::LPM_ACTIVE);
    endproperty
    a_idle_leave: assert property (p_idle_leave)
        else $error("stuck in active while idle");

    // wake activity in deep sleep drops to sleep unless an event is due
    property p_wake_leave_deep;
        @(posedge core_clk) disable iff (!arst_n)
        (mode == lpm_pkg::LPM_DEEP && wake_act && !link.event_due)
            |=> (mode == lpm_pkg::LPM_SLEEP);
    endproperty
    a_wake_leave_deep: assert property (p_wake_leave_deep)
        else $error("wake source did not leave deep sleep");

    // a link going live or usb appearing forces deep out to sleep
    property p_unsafe_deep;
        @(posedge core_clk) disable iff (!arst_n)
        (mode == lpm_pkg::LPM_DEEP && !deep_ok && !link.event_due)
            |=> (mode == lpm_pkg::LPM_SLEEP);
    endproperty
    a_unsafe_deep: assert property (p_unsafe_deep)
        else $error("deep sleep kept while not permitted");

    // slot work or a command in sleep brings the full clock back
    property p_sleep_busy;
        @(posedge core_clk) disable iff (!arst_n)
        (mode == lpm_pkg::LPM_SLEEP && busy)
            |=> (mode == lpm_pkg::LPM_ACTIVE);
    endproperty
    a_sleep_busy: assert property (p_sleep_busy)
        else $error("sleep ignored slot work or command");

    // the exchange of a deep sleep visit is over
    sequence s_visit_done;
        mode == lpm_pkg::LPM_ACTIVE && returned && !busy && deep_ok;
    endsequence
    property p_return_deep;
        @(posedge core_clk) disable iff (!arst_n)
        s_visit_done |=> (mode == lpm_pkg::LPM_DEEP);
    endproperty
    a_return_deep: assert property (p_return_deep)
        else $error("no return to deep sleep after exchange");

    // deep sleep is only reached with the serial link at rest, no usb
    property p_deep_needs_lp;
        @(posedge core_clk) disable iff (!arst_n)
        (mode == lpm_pkg::LPM_DEEP)
            |-> $past(uart_low_power && !usb_transport);
    endproperty
    a_deep_needs_lp: assert property (p_deep_needs_lp)
        else $error("deep sleep without serial low power");

    // quiet sleep with deep allowed goes down to deep sleep
    property p_sleep_to_deep;
        @(posedge core_clk) disable iff (!arst_n)
        (mode == lpm_pkg::LPM_SLEEP && !busy && deep_ok && !wake_act)
            |=> (mode == lpm_pkg::LPM_DEEP);
    endproperty
    a_sleep_to_deep: assert property (p_sleep_to_deep)
        else $error("sleep did not drop to deep sleep");

    // active runs every clock and keeps the fast reference
    property p_active_clk;
        @(posedge core_clk) disable iff (!arst_n)
        (mode == lpm_pkg::LPM_ACTIVE)
            |-> (part_clk_en && main_clk_en && sys_clk_req && !slow_clk_ref);
    endproperty
    a_active_clk: assert property (p_active_clk)
        else $error("active mode with a clock gated");

    // only the three held modes ever appear
    property p_mode_legal;
        @(posedge core_clk) disable iff (!arst_n)
        (mode == lpm_pkg::LPM_ACTIVE || mode == lpm_pkg::LPM_SLEEP
         || mode == lpm_pkg::LPM_DEEP);
    endproperty
    a_mode_legal: assert property (p_mode_legal)
        else $error("illegal mode code");

endmodule : lpm_manager

// [lpm_host_model.sv]
/*
 * host processor model on the far side of the serial hci transport.
 * assumes the bench commands it by levels changed at the clock edge.
 */
`timescale 1ns/1ps
module lpm_host_model (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic allow_deep,
    input wire logic send_cmd,
    output logic uart_low_power,
    output logic host_cmd_pending
);
    // link rests only while the host has nothing to send
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            uart_low_power <= 1'b0; // link open out of reset
            host_cmd_pending <= 1'b0;
        end else begin
            uart_low_power <= allow_deep & ~send_cmd;
            host_cmd_pending <= send_cmd; // sent over the reopened link
        end
    end
endmodule : lpm_host_model

// [lpm_manager_tb.sv]
/*
 * self-checking bench for the low power mode manager.
 * assumes the host model drives the serial link level and commands.
 */
`timescale 1ns/1ps
module lpm_manager_tb;
    logic core_clk, arst_n, usb_transport, allow_deep, send_cmd;
    lpm_pkg::lpm_link_t link_s; // radio link status
    lpm_pkg::lpm_wake_t wake_s; // wake sources
    logic uart_low_power, host_cmd_pending;
    lpm_pkg::lpm_mode_t mode, last_mode;
    logic part_clk_en, main_clk_en, sys_clk_req;
    logic host_cmd_accept, payload_en, slow_clk_ref;
    lpm_pkg::lpm_mode_t exp_q[$]; // expected mode changes, oldest first
    int n_mismatch, tests_run, i, n;
    logic [31:0] seed;

    lpm_manager dut (.core_clk(core_clk), .arst_n(arst_n), .link(link_s),
        .wake(wake_s), .uart_low_power(uart_low_power),
        .usb_transport(usb_transport), .host_cmd_pending(host_cmd_pending),
        .mode(mode), .part_clk_en(part_clk_en), .main_clk_en(main_clk_en),
        .sys_clk_req(sys_clk_req), .host_cmd_accept(host_cmd_accept),
        .payload_en(payload_en), .slow_clk_ref(slow_clk_ref));
    lpm_host_model host (.core_clk(core_clk), .arst_n(arst_n),
        .allow_deep(allow_deep), .send_cmd(send_cmd),
        .uart_low_power(uart_low_power),
        .host_cmd_pending(host_cmd_pending));

    // 100 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction : xs

    // every output follows from the mode alone
    task automatic check_outs(input lpm_pkg::lpm_mode_t m);
        logic [7:0] e, g;
        e = {m, m != lpm_pkg::LPM_DEEP, m == lpm_pkg::LPM_ACTIVE,
            m != lpm_pkg::LPM_DEEP, m != lpm_pkg::LPM_DEEP,
            m != lpm_pkg::LPM_DEEP, m != lpm_pkg::LPM_ACTIVE};
        g = {mode, part_clk_en, main_clk_en, sys_clk_req, host_cmd_accept,
            payload_en, slow_clk_ref};
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD mode_outputs expected %h seen %h", e, g);
        end
    endtask : check_outs

    // note a mode change, then wait a bounded time for it
    task automatic expect_mode(input lpm_pkg::lpm_mode_t m);
        exp_q.push_back(m);
        n = 0;
        while (exp_q.size() != 0 && n < 60) begin
            @(posedge core_clk);
            n++;
        end
        if (exp_q.size() != 0) begin
            n_mismatch++;
            $display("BAD mode_change expected %0d seen %0d", m, mode);
            exp_q.delete();
        end
    endtask : expect_mode

    // stay put for a while; any change meanwhile is caught by the monitor
    task automatic hold(input lpm_pkg::lpm_mode_t m);
        repeat (30) @(posedge core_clk);
        @(negedge core_clk);
        check_outs(m);
        @(posedge core_clk);
    endtask : hold

    task automatic end_of_test;
        $display("counts: %0d checks, %0d mismatches", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test

    // monitor: each mode change takes the oldest note
    always @(negedge core_clk) begin
        if (arst_n && mode !== last_mode) begin
            if (exp_q.size() == 0) begin
                n_mismatch++;
                $display("BAD mode_change expected %0d seen %0d", last_mode,
                    mode);
            end else begin
                check_outs(exp_q.pop_front());
            end
        end
        last_mode = mode;
    end

    // watchdog well beyond the longest run of waits
    initial begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        end_of_test();
    end

    initial begin
        arst_n = 1'b0;
        usb_transport = 1'b0;
        allow_deep = 1'b0;
        send_cmd = 1'b0;
        link_s = '0;
        wake_s = '0;
        n_mismatch = 0;
        tests_run = 0;
        seed = 32'h00008CB7;
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        check_outs(lpm_pkg::LPM_ACTIVE);
        @(posedge core_clk);
        arst_n <= 1'b1;
        link_s.sniff_park <= 1'b1; // link parked, host link open
        expect_mode(lpm_pkg::LPM_SLEEP);
        send_cmd <= 1'b1; // command traffic pulls it active
        expect_mode(lpm_pkg::LPM_ACTIVE);
        send_cmd <= 1'b0;
        expect_mode(lpm_pkg::LPM_SLEEP);
        allow_deep <= 1'b1;
        expect_mode(lpm_pkg::LPM_DEEP);
        $display("test sleep_and_deep done");
        link_s.event_due <= 1'b1; // sniff instant
        expect_mode(lpm_pkg::LPM_ACTIVE);
        link_s.event_due <= 1'b0;
        expect_mode(lpm_pkg::LPM_DEEP);
        link_s <= 6'h05; // scan only, window due
        expect_mode(lpm_pkg::LPM_ACTIVE);
        link_s.event_due <= 1'b0;
        expect_mode(lpm_pkg::LPM_DEEP);
        $display("test scheduled_wakeups done");
        for (i = 0; i < 6; i++) begin
            seed = xs(seed);
            if (i == 0) begin
                wake_s.gpio <= 16'h0001 << seed[3:0];
            end else begin
                wake_s <= lpm_pkg::lpm_wake_t'(21'h000001 << (i - 1));
            end
            expect_mode(lpm_pkg::LPM_SLEEP);
            wake_s <= '0;
            expect_mode(lpm_pkg::LPM_DEEP);
        end
        $display("test wake_sources done");
        allow_deep <= 1'b0; // host reopens the link
        expect_mode(lpm_pkg::LPM_SLEEP);
        link_s <= 6'h02; // busy slot
        expect_mode(lpm_pkg::LPM_ACTIVE);
        link_s <= 6'h20; // acl link, idle
        allow_deep <= 1'b1;
        expect_mode(lpm_pkg::LPM_SLEEP);
        hold(lpm_pkg::LPM_SLEEP);
        link_s <= 6'h00;
        usb_transport <= 1'b1;
        hold(lpm_pkg::LPM_SLEEP);
        usb_transport <= 1'b0;
        expect_mode(lpm_pkg::LPM_DEEP);
        $display("test deep_refusals done");
        end_of_test();
    end
endmodule : lpm_manager_tb
